// >>> pin_cell.sv
// One pin: registered drive and a three-stage input synchroniser
`timescale 1ns/1ns
`default_nettype none
module pin_cell (
   input wire logic core_clk, // System clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire pin_mux_pkg::pin_drive_s drive_nxt, // Decoded drive request
   input wire logic pin_in, // Raw pin level
   output pin_mux_pkg::pin_drive_s drive_r, // Registered drive
   output logic level_r // Filtered input level
);
   logic [pin_mux_pkg::SYNC_STAGES-1:0] sync_r;
   logic [pin_mux_pkg::SYNC_STAGES-1:0] sync_nxt;
   logic level_nxt;

   // Shift chain; stage 0 is only read by stage 1
   always_comb begin
      sync_nxt = {sync_r[pin_mux_pkg::SYNC_STAGES-2:0], pin_in};
      level_nxt = level_r;
      if (sync_r[1] == sync_r[2]) begin
         level_nxt = sync_r[2]; // Accept only once two stages agree
      end
   end

   // Reset to idle-high input so a floating receiver sees no start bit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_r <= '1;
         level_r <= pin_mux_pkg::IDLE_LEVEL;
         drive_r <= '0;
      end else begin
         sync_r <= sync_nxt;
         level_r <= level_nxt;
         drive_r <= drive_nxt;
      end
   end
endmodule : pin_cell
`default_nettype wire

// >>> pin_mux_pkg.sv
// Constants, mode codes and carrier types for the port pin-function selector
package pin_mux_pkg;
   // ----------------------------------------------------------------
   // Register map (index on the CPU register file; byte address = 4x)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_PORT1_PIN_MODE_LOW = 8'he3; // Bank one
   localparam logic [7:0] IDX_PORT2_PIN_MODE_HIGH = 8'he4; // Bank one
   localparam int ADDR_W = 10;
   localparam logic [1:0] WORD_LANE = 2'h0;
   localparam logic [7:0] MODE_REG_RESET = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Field positions and pin indices
   // ----------------------------------------------------------------
   localparam int NUM_PINS = 6;
   localparam int NUM_P1_PINS = 2;
   localparam int SYNC_STAGES = 3;
   // Pins 0..1 are port 1 pins 0..1, pins 2..5 are port 2 pins 4..7
   localparam int FIELD_LSB [NUM_PINS] = '{0, 2, 0, 2, 4, 6};
   localparam int PIN_P2_TX1 = 2;
   localparam int PIN_P2_RX1 = 3;
   localparam int PIN_P2_TX0 = 4;
   localparam int PIN_P2_RX0 = 5;
   localparam logic IDLE_LEVEL = 1'b1;

   // ----------------------------------------------------------------
   // Mode encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      P1_INPUT = 2'h0,
      P1_PULLUP = 2'h1,
      P1_ANALOG = 2'h2,
      P1_PUSH_PULL = 2'h3
   } port1_mode_e;

   typedef enum logic [1:0] {
      P2_INPUT = 2'h0,
      P2_ALT = 2'h1,
      P2_OPEN_DRAIN = 2'h2,
      P2_PUSH_PULL = 2'h3
   } port2_mode_e;

   // Drive request of one pin
   typedef struct packed {
      logic oe;
      logic out;
   } pin_drive_s;
endpackage : pin_mux_pkg

// >>> port_pin_function_select.sv
// Pin-function selector for port 1 pins 0..1 and port 2 pins 4..7
// Function
// - Port-1 pin-mode register at index e3 in bank one; bits 7..4 unused.
// - Port-2 upper pin-mode register at index e4 in bank one, fully read/write.
// - Port-1 pin 1 field: input, input with pull-up, analog nine, push-pull.
// - Port-1 pin 0 field: input, input with pull-up, analog eight, push-pull.
// - Receive pin fields: input to receiver, receiver drives, open-drain, push-pull.
// - Transmit pin fields: input, transmit drives pin, open-drain, push-pull.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module port_pin_function_select (
   input wire logic core_clk, // System clock, 125 MHz
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic [pin_mux_pkg::ADDR_W-1:0] address, // Avalon byte address
   input wire logic read, // Avalon read
   input wire logic write, // Avalon write
   input wire logic [31:0] writedata, // Avalon write data
   input wire logic [3:0] byteenable, // Avalon byte enables
   output logic [31:0] readdata, // Avalon read data
   output logic waitrequest, // Avalon wait request
   input wire logic [5:0] port_data, // Port data latch per pin
   input wire logic serial0_receive_out, // Receiver 0 drive value
   input wire logic serial0_transmit, // Transmitter 0 data
   input wire logic serial1_receive_out, // Receiver 1 drive value
   input wire logic serial1_transmit, // Transmitter 1 data
   input wire logic [5:0] pin_i, // Pin levels
   output logic [5:0] pin_o, // Pin output values
   output logic [5:0] pin_oe, // Pin output enables, high drives
   output logic [5:0] pin_level, // Filtered pin levels
   output logic [1:0] pullup_en, // Port 1 pull-up enables
   output logic analog_input_eight, // Port 1 pin 0 to analog channel eight
   output logic analog_input_nine, // Port 1 pin 1 to analog channel nine
   output logic serial0_receive, // Receiver 0 serial input
   output logic serial1_receive // Receiver 1 serial input
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] field_of(input logic [7:0] r, input int lsb);
      field_of = r[lsb +: 2];
   endfunction : field_of

   function automatic logic hits(input logic [pin_mux_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] idx);
      hits = (a[pin_mux_pkg::ADDR_W-1:2] == idx) && (a[1:0] == pin_mux_pkg::WORD_LANE);
   endfunction : hits

   // ----------------------------------------------------------------
   // Avalon slave and mode registers
   // ----------------------------------------------------------------
   logic [7:0] port1_pin_mode_low_r, port1_pin_mode_low_nxt;
   logic [7:0] port2_pin_mode_high_r, port2_pin_mode_high_nxt;
   logic wait_r, wait_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic hit_p1, hit_p2, wr_done;

   // One wait cycle, then a single-cycle accept; writes land on that edge
   always_comb begin
      hit_p1 = hits(address, pin_mux_pkg::IDX_PORT1_PIN_MODE_LOW);
      hit_p2 = hits(address, pin_mux_pkg::IDX_PORT2_PIN_MODE_HIGH);
      wr_done = write && !wait_r;
      wait_nxt = !(wait_r && (read || write));
      rdata_nxt = pin_mux_pkg::READ_ZERO; // Unmapped reads return zero
      if (read && wait_r) begin
         if (hit_p1) begin
            rdata_nxt = {24'h00_0000, port1_pin_mode_low_r};
         end else if (hit_p2) begin
            rdata_nxt = {24'h00_0000, port2_pin_mode_high_r};
         end
      end
      port1_pin_mode_low_nxt = port1_pin_mode_low_r;
      port2_pin_mode_high_nxt = port2_pin_mode_high_r;
      if (wr_done && byteenable[0] && hit_p1) begin
         port1_pin_mode_low_nxt = writedata[7:0];
      end
      if (wr_done && byteenable[0] && hit_p2) begin
         port2_pin_mode_high_nxt = writedata[7:0];
      end
   end

   // Registers for the bus side
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         port1_pin_mode_low_r <= pin_mux_pkg::MODE_REG_RESET;
         port2_pin_mode_high_r <= pin_mux_pkg::MODE_REG_RESET;
         wait_r <= 1'b1;
         rdata_r <= pin_mux_pkg::READ_ZERO;
      end else begin
         port1_pin_mode_low_r <= port1_pin_mode_low_nxt;
         port2_pin_mode_high_r <= port2_pin_mode_high_nxt;
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign readdata = rdata_r;
   assign waitrequest = wait_r;

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   pin_mux_pkg::pin_drive_s drive_nxt [pin_mux_pkg::NUM_PINS];
   pin_mux_pkg::pin_drive_s drive_r [pin_mux_pkg::NUM_PINS];
   logic [5:0] alt_out;
   logic [1:0] pullup_r, pullup_nxt, analog_r, analog_nxt;
   logic rx0_r, rx0_nxt, rx1_r, rx1_nxt;

   // Port 1 pins never drive in analog or pull-up modes
   always_comb begin
      alt_out = '0;
      alt_out[pin_mux_pkg::PIN_P2_TX1] = serial1_transmit;
      alt_out[pin_mux_pkg::PIN_P2_RX1] = serial1_receive_out;
      alt_out[pin_mux_pkg::PIN_P2_TX0] = serial0_transmit;
      alt_out[pin_mux_pkg::PIN_P2_RX0] = serial0_receive_out;
      pullup_nxt = '0;
      analog_nxt = '0;
      // Port 1 pins; a loop of its own keeps every index inside the 2-bit vectors
      for (int i = 0; i < pin_mux_pkg::NUM_P1_PINS; i++) begin
         drive_nxt[i] = '0;
         unique case (pin_mux_pkg::port1_mode_e'(field_of(port1_pin_mode_low_r,
                                                pin_mux_pkg::FIELD_LSB[i])))
            pin_mux_pkg::P1_INPUT: drive_nxt[i] = '0;
            pin_mux_pkg::P1_PULLUP: pullup_nxt[i] = 1'b1;
            pin_mux_pkg::P1_ANALOG: analog_nxt[i] = 1'b1;
            pin_mux_pkg::P1_PUSH_PULL: drive_nxt[i] = '{1'b1, port_data[i]};
         endcase
      end
      // Port 2 pins; the alternate source follows the pin's serial role
      for (int i = pin_mux_pkg::NUM_P1_PINS; i < pin_mux_pkg::NUM_PINS; i++) begin
         drive_nxt[i] = '0;
         unique case (pin_mux_pkg::port2_mode_e'(field_of(port2_pin_mode_high_r,
                                                pin_mux_pkg::FIELD_LSB[i])))
            pin_mux_pkg::P2_INPUT: drive_nxt[i] = '0;
            pin_mux_pkg::P2_ALT: drive_nxt[i] = '{1'b1, alt_out[i]};
            pin_mux_pkg::P2_OPEN_DRAIN: drive_nxt[i] = '{!port_data[i], 1'b0};
            pin_mux_pkg::P2_PUSH_PULL: drive_nxt[i] = '{1'b1, port_data[i]};
         endcase
      end
      // Receivers see idle high unless their pin is a plain input
      rx0_nxt = pin_mux_pkg::IDLE_LEVEL;
      rx1_nxt = pin_mux_pkg::IDLE_LEVEL;
      if (field_of(port2_pin_mode_high_r, pin_mux_pkg::FIELD_LSB[pin_mux_pkg::PIN_P2_RX0])
          == pin_mux_pkg::P2_INPUT) begin
         rx0_nxt = pin_level[pin_mux_pkg::PIN_P2_RX0];
      end
      if (field_of(port2_pin_mode_high_r, pin_mux_pkg::FIELD_LSB[pin_mux_pkg::PIN_P2_RX1])
          == pin_mux_pkg::P2_INPUT) begin
         rx1_nxt = pin_level[pin_mux_pkg::PIN_P2_RX1];
      end
   end

   // Registered side outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pullup_r <= '0;
         analog_r <= '0;
         rx0_r <= pin_mux_pkg::IDLE_LEVEL;
         rx1_r <= pin_mux_pkg::IDLE_LEVEL;
      end else begin
         pullup_r <= pullup_nxt;
         analog_r <= analog_nxt;
         rx0_r <= rx0_nxt;
         rx1_r <= rx1_nxt;
      end
   end

   assign pullup_en = pullup_r;
   assign analog_input_eight = analog_r[0];
   assign analog_input_nine = analog_r[1];
   assign serial0_receive = rx0_r;
   assign serial1_receive = rx1_r;

   // ----------------------------------------------------------------
   // Pin cells
   // ----------------------------------------------------------------
   for (genvar g = 0; g < pin_mux_pkg::NUM_PINS; g++) begin : g_pin
      pin_cell u_cell (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .drive_nxt(drive_nxt[g]),
         .pin_in(pin_i[g]),
         .drive_r(drive_r[g]),
         .level_r(pin_level[g])
      );
      assign pin_o[g] = drive_r[g].out;
      assign pin_oe[g] = drive_r[g].oe;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_p1_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      (write && !wait_r && hit_p1 && byteenable[0]) |=> port1_pin_mode_low_r == $past(writedata[7:0]))
      else $error("port 1 mode register missed a write");
   chk_p2_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      (write && !wait_r && hit_p2 && byteenable[0]) |=> port2_pin_mode_high_r == $past(writedata[7:0]))
      else $error("port 2 mode register missed a write");
   chk_p1_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
      (read && wait_r && hit_p1) |=> (!waitrequest && readdata[7:0] == $past(port1_pin_mode_low_r)))
      else $error("port 1 mode readback wrong");
   chk_pullup_pin1: assert property (@(posedge core_clk) disable iff (!rst_n)
      (field_of(port1_pin_mode_low_r, pin_mux_pkg::FIELD_LSB[1]) == pin_mux_pkg::P1_PULLUP) |=>
      (pullup_en[1] && !pin_oe[1]))
      else $error("pin 1 pull-up mode not applied");
   chk_analog_pin0: assert property (@(posedge core_clk) disable iff (!rst_n)
      (field_of(port1_pin_mode_low_r, pin_mux_pkg::FIELD_LSB[0]) == pin_mux_pkg::P1_ANALOG) |=>
      (analog_input_eight && !pin_oe[0]))
      else $error("pin 0 analog mode not applied");
   chk_rx_alt: assert property (@(posedge core_clk) disable iff (!rst_n)
      (field_of(port2_pin_mode_high_r, pin_mux_pkg::FIELD_LSB[pin_mux_pkg::PIN_P2_RX0])
       == pin_mux_pkg::P2_ALT) |=>
      (pin_oe[pin_mux_pkg::PIN_P2_RX0] &&
       pin_o[pin_mux_pkg::PIN_P2_RX0] == $past(serial0_receive_out)))
      else $error("receive pin not driven by receiver");
   chk_tx_alt: assert property (@(posedge core_clk) disable iff (!rst_n)
      (field_of(port2_pin_mode_high_r, pin_mux_pkg::FIELD_LSB[pin_mux_pkg::PIN_P2_TX0])
       == pin_mux_pkg::P2_ALT) |=>
      (pin_oe[pin_mux_pkg::PIN_P2_TX0] &&
       pin_o[pin_mux_pkg::PIN_P2_TX0] == $past(serial0_transmit)))
      else $error("transmit pin not driven by transmitter");
   chk_tx_drain: assert property (@(posedge core_clk) disable iff (!rst_n)
      (field_of(port2_pin_mode_high_r, pin_mux_pkg::FIELD_LSB[pin_mux_pkg::PIN_P2_TX1])
       == pin_mux_pkg::P2_OPEN_DRAIN) |=>
      (!pin_o[pin_mux_pkg::PIN_P2_TX1] &&
       pin_oe[pin_mux_pkg::PIN_P2_TX1] == !$past(port_data[pin_mux_pkg::PIN_P2_TX1])))
      else $error("transmit pin open-drain wrong");
   chk_reset_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n) |-> (port1_pin_mode_low_r == '0 && port2_pin_mode_high_r == '0 && pin_oe == '0))
      else $error("registers not clear after reset");
   chk_wait_one: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!waitrequest) |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   // A taken request is answered after exactly one wait cycle
   chk_wait_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
      ((read || write) && waitrequest) |=> !waitrequest)
      else $error("request not answered after one wait cycle");

   cov_p2_write: cover property (@(posedge core_clk) disable iff (!rst_n)
      write && !wait_r && hit_p2);
   cov_rx_input: cover property (@(posedge core_clk) disable iff (!rst_n)
      $fell(serial0_receive));
   cov_analog_nine: cover property (@(posedge core_clk) disable iff (!rst_n)
      $rose(analog_input_nine));
endmodule : port_pin_function_select
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the port pin-function selector
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   localparam logic [9:0] A_P1 = {pin_mux_pkg::IDX_PORT1_PIN_MODE_LOW, 2'h0};
   localparam logic [9:0] A_P2 = {pin_mux_pkg::IDX_PORT2_PIN_MODE_HIGH, 2'h0};
   localparam logic [9:0] A_NONE = 10'h394; // First word past the map
   logic core_clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
   logic [9:0] address = 10'h000;
   logic [31:0] writedata = 32'h0000_0000, readdata;
   logic [3:0] byteenable = 4'hf;
   logic [5:0] port_data = 6'h00, pin_i = 6'h00, pin_o, pin_oe, pin_level;
   logic s0_out = 1'b0, s0_tx = 1'b0, s1_out = 1'b0, s1_tx = 1'b0;
   logic waitrequest, analog_input_eight, analog_input_nine, serial0_receive, serial1_receive;
   logic [1:0] pullup_en;
   logic [31:0] rd;
   int error_cnt = 0, checks_done = 0;

   port_pin_function_select i_dut (.core_clk(core_clk), .rst_n(rst_n), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .port_data(port_data),
      .serial0_receive_out(s0_out), .serial0_transmit(s0_tx), .serial1_receive_out(s1_out),
      .serial1_transmit(s1_tx), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
      .pin_level(pin_level), .pullup_en(pullup_en), .analog_input_eight(analog_input_eight),
      .analog_input_nine(analog_input_nine), .serial0_receive(serial0_receive),
      .serial1_receive(serial1_receive));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // 125 MHz clock
   initial begin
      forever #4 core_clk = ~core_clk;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One Avalon transfer; the request stands until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge core_clk);
      address <= a;
      read <= ~wr;
      write <= wr;
      writedata <= {24'h0, d};
      byteenable <= be;
      do begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'b0);
      rd = readdata;
      chk("bus wait edges", 32'h2, n); // One wait cycle, accepted at the second edge
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   // Outputs are level signals; wait past the register and pin-filter latency
   task automatic settle();
      repeat (6) @(posedge core_clk);
   endtask : settle

   // Drives a port data pattern, the serial drive values and pin levels
   task automatic set_io(input logic p);
      port_data <= p ? 6'h2a : 6'h15;
      pin_i <= p ? 6'h28 : 6'h17;
      {s0_out, s0_tx, s1_out, s1_tx} <= p ? 4'ha : 4'h5;
   endtask : set_io

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset();
      chk("reset oe", 32'h0, {26'h0, pin_oe});
      chk("reset pullup", 32'h0, {30'h0, pullup_en});
      chk("reset analog", 32'h0, {30'h0, analog_input_nine, analog_input_eight});
      chk("reset receive", 32'h3, {30'h0, serial0_receive, serial1_receive});
      chk("reset level", 32'h3f, {26'h0, pin_level});
      bus(1'b0, A_P1, 8'h00, 4'hf);
      chk("reset port1 reg", 32'h0, rd);
      bus(1'b0, A_P2, 8'h00, 4'hf);
      chk("reset port2 reg", 32'h0, rd);
   endtask : test_reset

   // Every code on both port 1 fields, each with a different partner code, two data patterns
   task automatic test_port1();
      logic [1:0] c0, c1;
      for (int p = 0; p < 2; p++) begin
         set_io(p[0]);
         for (int m = 0; m < 4; m++) begin
            c0 = m[1:0];
            c1 = c0 + 2'h1;
            bus(1'b1, A_P1, {4'h0, c1, c0}, 4'hf);
            settle();
            chk("pullup", {30'h0, c1 == 2'h1, c0 == 2'h1}, {30'h0, pullup_en});
            chk("analog", {30'h0, c1 == 2'h2, c0 == 2'h2},
                {30'h0, analog_input_nine, analog_input_eight});
            chk("port1 oe", {30'h0, c1 == 2'h3, c0 == 2'h3}, {30'h0, pin_oe[1:0]});
            chk("port1 out", {30'h0, port_data[1:0] & {c1 == 2'h3, c0 == 2'h3}},
                {30'h0, pin_o[1:0]});
         end
      end
      bus(1'b1, A_P1, 8'hf0, 4'hf);
      bus(1'b0, A_P1, 8'h00, 4'hf);
      chk("port1 readback", 32'hf0, rd);
      settle();
      chk("unused bits", 32'h0, {28'h0, pin_oe[1:0], pullup_en});
   endtask : test_port1

   // Every code on all four serial pin fields, with two data polarities
   task automatic test_port2();
      logic [3:0] alt, eo, ex;
      for (int p = 0; p < 2; p++) begin
         set_io(p[0]);
         for (int m = 0; m < 4; m++) begin
            bus(1'b1, A_P2, {4{m[1:0]}}, 4'hf);
            settle();
            alt = {s0_out, s0_tx, s1_out, s1_tx};
            eo = (m == 0) ? 4'h0 : (m == 1) ? 4'hf : (m == 2) ? ~port_data[5:2] : 4'hf;
            ex = (m == 1) ? alt : (m == 2) ? 4'h0 : port_data[5:2];
            chk("port2 oe", {28'h0, eo}, {28'h0, pin_oe[5:2]});
            chk("port2 out", {28'h0, ex & eo}, {28'h0, pin_o[5:2] & eo});
            chk("pin level", {26'h0, pin_i}, {26'h0, pin_level});
            chk("receive", (m == 0) ? {30'h0, pin_i[5], pin_i[3]} : 32'h3,
                {30'h0, serial0_receive, serial1_receive});
            bus(1'b0, A_P2, 8'h00, 4'hf);
            chk("port2 readback", {24'h0, {4{m[1:0]}}}, rd);
         end
      end
   endtask : test_port2

   // Unmapped place and a write without its byte lane are both answered, not stored
   task automatic test_refused();
      bus(1'b1, A_P1, 8'h05, 4'hf);
      bus(1'b1, A_P1, 8'h0a, 4'he);
      bus(1'b1, A_NONE, 8'h55, 4'hf);
      bus(1'b0, A_NONE, 8'h00, 4'hf);
      chk("unmapped read", 32'h0, rd);
      bus(1'b0, A_P1, 8'h00, 4'hf);
      chk("lane off write", 32'h05, rd);
      bus(1'b1, A_P2, 8'ha5, 4'hf);
      bus(1'b0, A_P2, 8'h00, 4'hf);
      chk("port2 full byte", 32'ha5, rd);
   endtask : test_refused

   // Reset in mid-run, while both registers hold nonzero codes
   task automatic test_reset_again();
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      test_reset();
   endtask : test_reset_again

   // ----------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ----------------------------------------------------------------
   task automatic test_done();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done

   // The sequence needs well under 2000 cycles; a hang is cut at 20000
   initial begin
      #160000;
      error_cnt++;
      test_done();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      test_reset();
      test_port1();
      test_port2();
      test_refused();
      test_reset_again();
      test_done();
   end
endmodule : tb_top
`default_nettype wire
